// file: urm_pkg.sv
// Purpose: Shared constants and types for the dual UART register map.
// Assumes: Eight-bit registers, three address lines, two channels.
// Notes: Every channel bank register resets to REG_RST; pin and synchronizer stages reset high.
package urm_pkg;
  localparam int NCH = 2;
  localparam int DW = 8;
  localparam int AW = 3;
  localparam int FRAC_W = 4;

  localparam logic [2:0] A_DATA = 3'h0;
  localparam logic [2:0] A_INTEN = 3'h1;
  localparam logic [2:0] A_ISTAT = 3'h2;
  localparam logic [2:0] A_LINE = 3'h3;
  localparam logic [2:0] A_MODEM = 3'h4;
  localparam logic [2:0] A_LSTAT = 3'h5;
  localparam logic [2:0] A_MSTAT = 3'h6;
  localparam logic [2:0] A_SCR = 3'h7;

  localparam logic [7:0] LC_ENH = 8'hbf;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] RD_NONE = 8'h00;
  localparam logic [3:0] FRAC_PAD = 4'h0;
  localparam logic [15:0] DIV_ZERO = 16'h0000;
  localparam logic PIN_HOLD = 1'b1;

  localparam int LC_DIV_BIT = 7;
  localparam int MC_DTR_BIT = 0;
  localparam int MC_RTS_BIT = 1;
  localparam int MC_OUT1_BIT = 2;
  localparam int MC_OUT2_BIT = 3;
  localparam int MC_LOOP_BIT = 4;
  localparam int EF_ENH_BIT = 4;
  localparam int FT_LVL_BIT = 6;

  typedef struct packed {
    logic cs_a_n;
    logic cs_b_n;
    logic rd_n;
    logic wr_n;
    logic [2:0] addr;
    logic [7:0] data;
  } bus_t;

  typedef struct packed {
    logic rx;
    logic cts_n;
    logic dsr_n;
    logic cd_n;
    logic ri_n;
  } pin_t;

  typedef enum logic [4:0] {
    S_NONE = 5'b00000, S_RX_HOLD = 5'b00001, S_TX_HOLD = 5'b00010,
    S_DIV_LO = 5'b00011, S_DIV_HI = 5'b00100, S_DIV_FRAC = 5'b00101,
    S_REV = 5'b00110, S_DEV_ID = 5'b00111, S_INT_EN = 5'b01000,
    S_INT_STAT = 5'b01001, S_FIFO_CTL = 5'b01010, S_LINE_CTL = 5'b01011,
    S_MODEM_CTL = 5'b01100, S_LINE_STAT = 5'b01101, S_MODEM_STAT = 5'b01110,
    S_SCRATCH = 5'b01111, S_FIFO_LVL = 5'b10000, S_MODE_SEL = 5'b10001,
    S_TRIG = 5'b10010, S_LVL_ENH = 5'b10011, S_FEAT_CTL = 5'b10100,
    S_ENH_FN = 5'b10101, S_RESUME1 = 5'b10110, S_RESUME2 = 5'b10111,
    S_PAUSE1 = 5'b11000, S_PAUSE2 = 5'b11001
  } reg_sel_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_READ = 2'b01,
    BUS_WRITE = 2'b10
  } bus_state_t;
endpackage

// file: urm_chan_bank.sv
// Purpose: Register storage and read mux of one UART channel.
// Assumes: Register select is decoded by the parent.
// Notes: Load and pop outputs are one-cycle pulses.
`timescale 1ns/1ns
module urm_chan_bank #(
  parameter logic [7:0] REV_CODE = 8'h01,
  parameter logic [7:0] DEV_ID = 8'h5a
) (
  input logic clk_i,
  input logic nrst_i,
  input urm_pkg::reg_sel_t sel_i,
  input logic wr_i,
  input logic rd_end_i,
  input logic [7:0] wdata_i,
  input logic [7:0] rx_holding_i,
  input logic [7:0] int_status_i,
  input logic [7:0] line_status_i,
  input logic [7:0] fifo_level_i,
  input logic [3:0] modem_i,
  output logic [7:0] rdata_o,
  output logic [7:0] line_ctl_o,
  output logic [7:0] modem_ctl_o,
  output logic [7:0] enh_fn_o,
  output logic [7:0] feat_ctl_o,
  output logic [15:0] baud_div_o,
  output logic tx_load_o,
  output logic fifo_ctl_load_o,
  output logic trig_load_o,
  output logic mode_sel_load_o,
  output logic rx_pop_o
);
  typedef struct packed {
    logic [7:0] line_ctl;
    logic [7:0] modem_ctl;
    logic [7:0] int_en;
    logic [7:0] div_lo;
    logic [7:0] div_hi;
    logic [3:0] div_frac;
    logic [7:0] scratch;
    logic [7:0] enh_fn;
    logic [7:0] feat_ctl;
    logic [7:0] resume1;
    logic [7:0] resume2;
    logic [7:0] pause1;
    logic [7:0] pause2;
    logic [3:0] modem_prev;
    logic [3:0] modem_delta;
    logic [4:0] pulse;
  } bank_t;

  bank_t q;
  bank_t n;

  always_comb begin
    n = q;
    n.pulse = 5'h00;
    n.modem_prev = modem_i;
    // Change flags clear on a status read, but a new change wins
    if (rd_end_i && sel_i == urm_pkg::S_MODEM_STAT) begin
      n.modem_delta = 4'h0;
    end
    n.modem_delta = n.modem_delta | (modem_i ^ q.modem_prev);
    if (rd_end_i && sel_i == urm_pkg::S_RX_HOLD) begin
      n.pulse[0] = 1'b1;
    end
    if (wr_i) begin
      case (sel_i)
        urm_pkg::S_TX_HOLD: n.pulse[1] = 1'b1; // RQ7
        urm_pkg::S_FIFO_CTL: n.pulse[2] = 1'b1; // RQ12
        urm_pkg::S_TRIG: n.pulse[3] = 1'b1; // RQ19
        urm_pkg::S_MODE_SEL: n.pulse[4] = 1'b1; // RQ18
        urm_pkg::S_DIV_LO: n.div_lo = wdata_i; // RQ8
        urm_pkg::S_DIV_HI: n.div_hi = wdata_i; // RQ8
        urm_pkg::S_DIV_FRAC: n.div_frac = wdata_i[3:0]; // RQ9
        urm_pkg::S_INT_EN: n.int_en = wdata_i; // RQ11
        urm_pkg::S_LINE_CTL: n.line_ctl = wdata_i; // RQ13
        urm_pkg::S_MODEM_CTL: n.modem_ctl = wdata_i; // RQ1 RQ14
        urm_pkg::S_SCRATCH: n.scratch = wdata_i; // RQ16
        urm_pkg::S_FEAT_CTL: n.feat_ctl = wdata_i; // RQ20
        urm_pkg::S_ENH_FN: n.enh_fn = wdata_i; // RQ20
        urm_pkg::S_RESUME1: n.resume1 = wdata_i; // RQ21
        urm_pkg::S_RESUME2: n.resume2 = wdata_i; // RQ21
        urm_pkg::S_PAUSE1: n.pause1 = wdata_i; // RQ21
        urm_pkg::S_PAUSE2: n.pause2 = wdata_i; // RQ21
        default: ; // RQ22
      endcase
    end
    case (sel_i)
      urm_pkg::S_RX_HOLD: rdata_o = rx_holding_i; // RQ7
      urm_pkg::S_DIV_LO: rdata_o = q.div_lo;
      urm_pkg::S_DIV_HI: rdata_o = q.div_hi;
      urm_pkg::S_DIV_FRAC: rdata_o = {urm_pkg::FRAC_PAD, q.div_frac};
      urm_pkg::S_REV: rdata_o = REV_CODE; // RQ10
      urm_pkg::S_DEV_ID: rdata_o = DEV_ID; // RQ10
      urm_pkg::S_INT_EN: rdata_o = q.int_en;
      urm_pkg::S_INT_STAT: rdata_o = int_status_i; // RQ12
      urm_pkg::S_LINE_CTL: rdata_o = q.line_ctl;
      urm_pkg::S_MODEM_CTL: rdata_o = q.modem_ctl;
      urm_pkg::S_LINE_STAT: rdata_o = line_status_i; // RQ15
      urm_pkg::S_MODEM_STAT: rdata_o = {q.modem_prev, q.modem_delta}; // RQ14
      urm_pkg::S_SCRATCH: rdata_o = q.scratch;
      urm_pkg::S_FIFO_LVL: rdata_o = fifo_level_i; // RQ17
      urm_pkg::S_LVL_ENH: rdata_o = fifo_level_i; // RQ19
      urm_pkg::S_FEAT_CTL: rdata_o = q.feat_ctl;
      urm_pkg::S_ENH_FN: rdata_o = q.enh_fn;
      urm_pkg::S_RESUME1: rdata_o = q.resume1;
      urm_pkg::S_RESUME2: rdata_o = q.resume2;
      urm_pkg::S_PAUSE1: rdata_o = q.pause1;
      urm_pkg::S_PAUSE2: rdata_o = q.pause2;
      default: rdata_o = urm_pkg::RD_NONE; // RQ22
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign line_ctl_o = q.line_ctl;
  assign modem_ctl_o = q.modem_ctl;
  assign enh_fn_o = q.enh_fn;
  assign feat_ctl_o = q.feat_ctl;
  assign baud_div_o = {q.div_hi, q.div_lo};
  assign rx_pop_o = q.pulse[0];
  assign tx_load_o = q.pulse[1];
  assign fifo_ctl_load_o = q.pulse[2];
  assign trig_load_o = q.pulse[3];
  assign mode_sel_load_o = q.pulse[4];
endmodule

// file: dual_uart_regmap_loopback.sv
// Purpose: Host port, register decode and loopback of a dual UART.
// Assumes: Host strobes are asynchronous and held for three clocks.
// Notes: FIFOs, baud generator and shifters sit outside.
//
// Operation
// RQ1: Modem control bit 4 set enters loopback; clearing it leaves.
// RQ2: Loopback feeds transmit shift output into receive input.
// RQ3: Loopback holds tx, rts, dtr high and ignores modem inputs.
// RQ4: No automatic rts/cts flow control during loopback.
// RQ5: Host keeps rx pin high through a loopback test.
// RQ6: Each channel has own registers, picked by own select.
// RQ7: Address 0, divisor off: read rx holding, write tx holding.
// RQ8: Divisor mode, not 0xbf: addresses 0, 1 reach divisor bytes.
// RQ9: Divisor mode with enhance bit: address 2 reaches fraction.
// RQ10: Zero divisor in divisor mode: reads give revision and id.
// RQ11: Address 1, divisor off: interrupt enable register.
// RQ12: Address 2, not 0xbf: read status, write fifo control.
// RQ13: Address 3 always reaches line control.
// RQ14: Address 4 modem control, address 6 modem status.
// RQ15: Address 5, not 0xbf: read-only line status.
// RQ16: Address 7, level bit clear: scratch register.
// RQ17: Address 7, level bit set: reads give fifo level.
// RQ18: Address 7, level bit set: writes go to mode select.
// RQ19: Line control 0xbf, address 0: write trigger, read level.
// RQ20: Enhanced bank: address 1 feature, address 2 function.
// RQ21: Enhanced bank 4..7: resume 1, resume 2, pause 1, pause 2.
// RQ22: Writes to read-only slots ignored; no stray read effects.
////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
module dual_uart_regmap_loopback #(
  // Identification values are arbitrary
  parameter logic [7:0] REV_CODE = 8'h01,
  parameter logic [7:0] DEV_ID = 8'h5a
) (
  input logic clk_i,
  input logic nrst_i,
  input logic [2:0] addr_i,
  input logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  input logic rd_n_i,
  input logic wr_n_i,
  input logic channel_a_select_n_i,
  input logic channel_b_select_n_i,
  input logic [1:0] rx_i,
  input logic [1:0] cts_n_i,
  input logic [1:0] dsr_n_i,
  input logic [1:0] cd_n_i,
  input logic [1:0] ri_n_i,
  output logic [1:0] tx_o,
  output logic [1:0] rts_n_o,
  output logic [1:0] dtr_n_o,
  input logic [1:0] tx_serial_i,
  output logic [1:0] core_rx_o,
  input logic [1:0][7:0] rx_holding_i,
  input logic [1:0][7:0] int_status_i,
  input logic [1:0][7:0] line_status_i,
  input logic [1:0][7:0] fifo_level_i,
  output logic [1:0] loopback_o,
  output logic [1:0][15:0] baud_div_o,
  output logic [7:0] load_data_o,
  output logic [1:0] tx_load_o,
  output logic [1:0] fifo_ctl_load_o,
  output logic [1:0] trig_load_o,
  output logic [1:0] mode_sel_load_o,
  output logic [1:0] rx_pop_o
);
  typedef struct packed {
    urm_pkg::bus_t bs1;
    urm_pkg::bus_t bs2;
    urm_pkg::pin_t [1:0] ps1;
    urm_pkg::pin_t [1:0] ps2;
    urm_pkg::bus_state_t st;
    logic ch;
    logic [2:0] addr;
    logic [7:0] data;
    urm_pkg::reg_sel_t rsel;
    logic [7:0] rdata;
    logic oe;
    logic [1:0] tx;
    logic [1:0] rts_n;
    logic [1:0] dtr_n;
    logic [1:0] core_rx;
    logic [1:0] loop;
  } main_t;

  main_t q;
  main_t n;

  urm_pkg::reg_sel_t sel [2];
  logic [1:0] wr_b;
  logic [1:0] rd_b;
  logic [1:0][3:0] modem;
  logic [1:0][7:0] rdata_b;
  logic [1:0][7:0] lc;
  logic [1:0][7:0] mc;
  logic [1:0][7:0] ef;
  logic [1:0][7:0] ft;
  logic cs_one;
  logic ch_now;
  logic rd_go;
  logic wr_go;

  ////////////////////////////////////////////////////////////////
  // Register select from address and bank state
  function automatic urm_pkg::reg_sel_t decode(
    input logic [2:0] a,
    input logic wr,
    input logic [7:0] lcv,
    input logic efn,
    input logic lvl,
    input logic dz
  );
    logic enh;
    logic div;
    enh = (lcv == urm_pkg::LC_ENH);
    div = lcv[urm_pkg::LC_DIV_BIT] && !enh;
    decode = urm_pkg::S_NONE;
    case (a)
      urm_pkg::A_DATA: begin
        if (enh) begin
          decode = wr ? urm_pkg::S_TRIG : urm_pkg::S_LVL_ENH; // RQ19
        end else if (div) begin
          decode = (dz && !wr) ? urm_pkg::S_REV : urm_pkg::S_DIV_LO; // RQ8 RQ10
        end else begin
          decode = wr ? urm_pkg::S_TX_HOLD : urm_pkg::S_RX_HOLD; // RQ7
        end
      end
      urm_pkg::A_INTEN: begin
        if (enh) begin
          decode = urm_pkg::S_FEAT_CTL; // RQ20
        end else if (div) begin
          decode = (dz && !wr) ? urm_pkg::S_DEV_ID : urm_pkg::S_DIV_HI; // RQ8 RQ10
        end else begin
          decode = urm_pkg::S_INT_EN; // RQ11
        end
      end
      urm_pkg::A_ISTAT: begin
        if (enh) begin
          decode = urm_pkg::S_ENH_FN; // RQ20
        end else if (div && efn) begin
          decode = urm_pkg::S_DIV_FRAC; // RQ9
        end else begin
          decode = wr ? urm_pkg::S_FIFO_CTL : urm_pkg::S_INT_STAT; // RQ12
        end
      end
      urm_pkg::A_LINE: decode = urm_pkg::S_LINE_CTL; // RQ13
      urm_pkg::A_MODEM: decode = enh ? urm_pkg::S_RESUME1 : urm_pkg::S_MODEM_CTL; // RQ14 RQ21
      urm_pkg::A_LSTAT: begin
        if (enh) begin
          decode = urm_pkg::S_RESUME2; // RQ21
        end else if (!wr) begin
          decode = urm_pkg::S_LINE_STAT; // RQ15 RQ22
        end
      end
      urm_pkg::A_MSTAT: begin
        if (enh) begin
          decode = urm_pkg::S_PAUSE1; // RQ21
        end else if (!wr) begin
          decode = urm_pkg::S_MODEM_STAT; // RQ14 RQ22
        end
      end
      urm_pkg::A_SCR: begin
        if (enh) begin
          decode = urm_pkg::S_PAUSE2; // RQ21
        end else if (lvl) begin
          decode = wr ? urm_pkg::S_MODE_SEL : urm_pkg::S_FIFO_LVL; // RQ17 RQ18
        end else begin
          decode = urm_pkg::S_SCRATCH; // RQ16
        end
      end
      default: decode = urm_pkg::S_NONE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////
  // Host port sequencing and loopback pin steering
  always_comb begin
    n = q;
    n.bs1 = {channel_a_select_n_i, channel_b_select_n_i, rd_n_i, wr_n_i, addr_i, data_i};
    n.bs2 = q.bs1;
    cs_one = q.bs2.cs_a_n ^ q.bs2.cs_b_n; // RQ6
    ch_now = q.bs2.cs_a_n;
    rd_go = 1'b0;
    wr_go = 1'b0;
    for (int c = 0; c < urm_pkg::NCH; c++) begin
      if (q.st == urm_pkg::BUS_READ) begin
        sel[c] = q.rsel;
      end else begin
        sel[c] = decode((q.st == urm_pkg::BUS_IDLE) ? q.bs2.addr : q.addr,
                        q.st == urm_pkg::BUS_WRITE, lc[c],
                        ef[c][urm_pkg::EF_ENH_BIT], ft[c][urm_pkg::FT_LVL_BIT],
                        baud_div_o[c] == urm_pkg::DIV_ZERO);
      end
    end
    case (q.st)
      urm_pkg::BUS_IDLE: begin
        if (cs_one && !q.bs2.rd_n) begin
          n.st = urm_pkg::BUS_READ;
          n.ch = ch_now;
          n.addr = q.bs2.addr;
          n.rsel = sel[ch_now];
          n.rdata = rdata_b[ch_now];
          n.oe = 1'b1;
        end else if (cs_one && !q.bs2.wr_n) begin
          n.st = urm_pkg::BUS_WRITE;
          n.ch = ch_now;
          n.addr = q.bs2.addr;
          n.data = q.bs2.data;
        end
      end
      urm_pkg::BUS_READ: begin
        if (q.bs2.rd_n) begin
          n.st = urm_pkg::BUS_IDLE;
          n.oe = 1'b0;
          rd_go = 1'b1;
        end
      end
      urm_pkg::BUS_WRITE: begin
        if (q.bs2.wr_n) begin
          n.st = urm_pkg::BUS_IDLE;
          wr_go = 1'b1;
        end else begin
          n.addr = q.bs2.addr;
          n.data = q.bs2.data;
        end
      end
      default: n.st = urm_pkg::BUS_IDLE;
    endcase
    for (int c = 0; c < urm_pkg::NCH; c++) begin
      wr_b[c] = wr_go && (q.ch == 1'(c)); // RQ6
      rd_b[c] = rd_go && (q.ch == 1'(c));
      n.ps1[c] = {rx_i[c], cts_n_i[c], dsr_n_i[c], cd_n_i[c], ri_n_i[c]};
      n.ps2[c] = q.ps1[c];
      n.loop[c] = mc[c][urm_pkg::MC_LOOP_BIT]; // RQ1
      if (mc[c][urm_pkg::MC_LOOP_BIT]) begin
        n.tx[c] = urm_pkg::PIN_HOLD; // RQ3
        n.rts_n[c] = urm_pkg::PIN_HOLD; // RQ3 RQ4
        n.dtr_n[c] = urm_pkg::PIN_HOLD; // RQ3
        n.core_rx[c] = tx_serial_i[c]; // RQ2
        // Modem status follows modem control outputs, not the pins
        modem[c] = {mc[c][urm_pkg::MC_OUT2_BIT], mc[c][urm_pkg::MC_OUT1_BIT],
                    mc[c][urm_pkg::MC_DTR_BIT], mc[c][urm_pkg::MC_RTS_BIT]}; // RQ3
      end else begin
        n.tx[c] = tx_serial_i[c];
        n.rts_n[c] = !mc[c][urm_pkg::MC_RTS_BIT]; // RQ4
        n.dtr_n[c] = !mc[c][urm_pkg::MC_DTR_BIT];
        n.core_rx[c] = q.ps2[c].rx; // RQ5
        modem[c] = ~{q.ps2[c].cd_n, q.ps2[c].ri_n, q.ps2[c].dsr_n, q.ps2[c].cts_n};
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
      q.bs1 <= '1;
      q.bs2 <= '1;
      q.ps1 <= '1;
      q.ps2 <= '1;
      q.tx <= '1;
      q.rts_n <= '1;
      q.dtr_n <= '1;
      q.core_rx <= '1;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////
  // One register set per channel
  for (genvar g = 0; g < urm_pkg::NCH; g++) begin : g_chan
    urm_chan_bank #(
      .REV_CODE(REV_CODE),
      .DEV_ID(DEV_ID)
    ) u_bank (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .sel_i(sel[g]),
      .wr_i(wr_b[g]),
      .rd_end_i(rd_b[g]),
      .wdata_i(q.data),
      .rx_holding_i(rx_holding_i[g]),
      .int_status_i(int_status_i[g]),
      .line_status_i(line_status_i[g]),
      .fifo_level_i(fifo_level_i[g]),
      .modem_i(modem[g]),
      .rdata_o(rdata_b[g]),
      .line_ctl_o(lc[g]),
      .modem_ctl_o(mc[g]),
      .enh_fn_o(ef[g]),
      .feat_ctl_o(ft[g]),
      .baud_div_o(baud_div_o[g]),
      .tx_load_o(tx_load_o[g]),
      .fifo_ctl_load_o(fifo_ctl_load_o[g]),
      .trig_load_o(trig_load_o[g]),
      .mode_sel_load_o(mode_sel_load_o[g]),
      .rx_pop_o(rx_pop_o[g])
    );
  end

  assign data_o = q.rdata;
  assign data_oe_o = q.oe;
  assign load_data_o = q.data;
  assign tx_o = q.tx;
  assign rts_n_o = q.rts_n;
  assign dtr_n_o = q.dtr_n;
  assign core_rx_o = q.core_rx;
  assign loopback_o = q.loop;

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_rd_start(int c, logic [2:0] a);
    q.st == urm_pkg::BUS_IDLE && cs_one && !q.bs2.rd_n && ch_now == c && q.bs2.addr == a;
  endsequence

  sequence s_wr_commit(int c, logic [2:0] a);
    wr_go && q.ch == c && q.addr == a;
  endsequence

  a_chan_pick: // RQ6
    assert property (q.st == urm_pkg::BUS_IDLE && !q.bs2.cs_a_n && q.bs2.cs_b_n && !q.bs2.rd_n
                     |=> !q.ch && data_oe_o)
    else $error("channel a read not routed to channel a");

  for (genvar g = 0; g < urm_pkg::NCH; g++) begin : g_chk
    a_loop_pins_held: // RQ3
      assert property (mc[g][urm_pkg::MC_LOOP_BIT] |=> tx_o[g] && rts_n_o[g] && dtr_n_o[g])
      else $error("pins not held in loopback");

    a_loop_rx_path: // RQ2
      assert property (mc[g][urm_pkg::MC_LOOP_BIT] |=> core_rx_o[g] == $past(tx_serial_i[g]))
      else $error("loopback data path broken");

    a_normal_rx_sync: // RQ1
      assert property (!mc[g][urm_pkg::MC_LOOP_BIT] |=> core_rx_o[g] == $past(rx_i[g], 3))
      else $error("receive pin not passed outside loopback");

    a_loop_enter: // RQ1
      assert property (s_wr_commit(g, urm_pkg::A_MODEM) ##0 (lc[g] != urm_pkg::LC_ENH && q.data[4])
                       |=> mc[g][urm_pkg::MC_LOOP_BIT] ##1 loopback_o[g] && tx_o[g])
      else $error("loopback not entered");

    a_tx_load_addr: // RQ7
      assert property (s_wr_commit(g, urm_pkg::A_DATA) ##0 !lc[g][urm_pkg::LC_DIV_BIT]
                       |=> tx_load_o[g] ##1 !tx_load_o[g])
      else $error("transmit load pulse wrong");

    a_line_always: // RQ13
      assert property (s_wr_commit(g, urm_pkg::A_LINE) |=> lc[g] == $past(q.data))
      else $error("line control not written");

    a_div_read: // RQ8
      assert property (s_rd_start(g, urm_pkg::A_DATA) ##0 (lc[g][urm_pkg::LC_DIV_BIT]
                       && lc[g] != urm_pkg::LC_ENH && baud_div_o[g] != urm_pkg::DIV_ZERO)
                       |=> data_oe_o && data_o == $past(baud_div_o[g][7:0]))
      else $error("divisor low byte read wrong");

    a_id_read: // RQ10
      assert property (s_rd_start(g, urm_pkg::A_INTEN) ##0 (lc[g][urm_pkg::LC_DIV_BIT]
                       && lc[g] != urm_pkg::LC_ENH && baud_div_o[g] == urm_pkg::DIV_ZERO)
                       |=> data_o == DEV_ID)
      else $error("identification read wrong");

    a_ro_ignored: // RQ22
      assert property (s_wr_commit(g, urm_pkg::A_MSTAT) ##0 lc[g] != urm_pkg::LC_ENH
                       |=> $stable(mc[g]) && $stable(lc[g]) && !tx_load_o[g])
      else $error("read-only write changed state");

    a_resume_slot: // RQ21
      assert property (s_wr_commit(g, urm_pkg::A_MODEM) ##0 lc[g] == urm_pkg::LC_ENH
                       |=> $stable(mc[g]))
      else $error("enhanced bank write reached modem control");
  end
endmodule

// file: host_model.sv
// Purpose: Host processor model on the register port.
// Assumes: Strobes change only just after a rising edge.
// Notes: Released data lines show the inverse of the last byte.
`timescale 1ns/1ns
module host_model (
  input wire logic clk_i,
  input wire logic [7:0] data_o,
  input wire logic data_oe_o,
  output logic [2:0] addr_o,
  output logic [7:0] wdata_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic sel_a_n_o,
  output logic sel_b_n_o
);
  initial begin
    addr_o = 3'h0;
    wdata_o = 8'h00;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    sel_a_n_o = 1'b1;
    sel_b_n_o = 1'b1;
  end
  ////////////////////////////////////////////////////////////////
  // One access; strobe low at least four edges, idle six after
  task automatic access(input logic ch, input logic [2:0] a, input logic wr, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    sel_a_n_o <= ch;
    sel_b_n_o <= !ch;
    if (wr) wr_n_o <= 1'b0;
    else rd_n_o <= 1'b0;
    for (int n = 0; n < 8; n++) begin
      @(posedge clk_i);
      #1;
      if (wr ? n == 3 : data_oe_o === 1'b1) break;
    end
    q = data_o;
    @(posedge clk_i);
    rd_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    sel_a_n_o <= 1'b1;
    sel_b_n_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    wdata_o <= ~d;
    repeat (3) @(posedge clk_i);
  endtask
endmodule

// file: dual_uart_regmap_loopback_tb.sv
// Purpose: Self-checking bench of the dual UART register map.
// Assumes: host_model drives the register port.
// Notes: Core status inputs are random, fixed after reset.
`timescale 1ns/1ns
module dual_uart_regmap_loopback_tb;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [2:0] addr;
  logic [7:0] wdata, dout, q, v, ldat;
  logic oe, rd_n, wr_n, csa_n, csb_n;
  logic [1:0] rx_i = 2'b11;
  logic [1:0] mdm_n = 2'b11;
  logic [1:0] txs = 2'b00;
  logic [1:0] tx, rts_n, dtr_n, crx, lb, ld_tx, ld_fc, ld_tg, ld_ms, pop;
  logic [1:0][7:0] rxh = 16'h0000, ist = 16'h0000, lst = 16'h0000, flv = 16'h0000;
  logic [1:0][15:0] bdiv;
  logic [9:0] seen = 10'h000;
  integer seed = 32'heb2ac8d4;
  int err_count = 0;
  int checks_done = 0;
  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    seen <= seen | {pop, ld_tg, ld_fc, ld_ms, ld_tx};
    txs <= 2'($random(seed));
    // Channel b never loops back, so its receive pin may toggle
    if (nrst_i) rx_i[1] <= 1'($random(seed));
  end
  // Identification values are arbitrary
  dual_uart_regmap_loopback #(.REV_CODE(8'h3c), .DEV_ID(8'hc3)) dual_uart_regmap_loopback_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr), .data_i(wdata), .data_o(dout), .data_oe_o(oe),
    .rd_n_i(rd_n), .wr_n_i(wr_n), .channel_a_select_n_i(csa_n), .channel_b_select_n_i(csb_n),
    .rx_i(rx_i), .cts_n_i(mdm_n), .dsr_n_i(mdm_n), .cd_n_i(mdm_n), .ri_n_i(mdm_n), .tx_o(tx),
    .rts_n_o(rts_n), .dtr_n_o(dtr_n), .tx_serial_i(txs), .core_rx_o(crx), .rx_holding_i(rxh),
    .int_status_i(ist), .line_status_i(lst), .fifo_level_i(flv), .loopback_o(lb), .baud_div_o(bdiv),
    .load_data_o(ldat), .tx_load_o(ld_tx), .fifo_ctl_load_o(ld_fc), .trig_load_o(ld_tg),
    .mode_sel_load_o(ld_ms), .rx_pop_o(pop));
  host_model host_model_i (.clk_i(clk_i), .data_o(dout), .data_oe_o(oe), .addr_o(addr), .wdata_o(wdata),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .sel_a_n_o(csa_n), .sel_b_n_o(csb_n));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
    logic [7:0] r;
    host_model_i.access(ch, a, 1'b1, d, r);
  endtask
  task automatic rdc(input string nm, input logic ch, input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] r;
    host_model_i.access(ch, a, 1'b0, 8'h00, r);
    chk(nm, exp, r);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge clk_i);
    err_count++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    rxh <= 16'($random(seed));
    ist <= 16'($random(seed));
    lst <= 16'($random(seed));
    flv <= 16'($random(seed));
    rdc("line_ctl", 1'b0, 3'h3, 8'h00);
    for (int c = 0; c < 2; c++) begin
      wr(c[0], 3'h3, 8'h80);
      rdc("revision", c[0], 3'h0, 8'h3c);
      rdc("dev_id", c[0], 3'h1, 8'hc3);
    end
    v = 8'($random(seed)) | 8'h01;
    wr(1'b0, 3'h0, v);
    wr(1'b0, 3'h1, ~v);
    rdc("div_lo", 1'b0, 3'h0, v);
    rdc("div_hi", 1'b0, 3'h1, ~v);
    chk("baud_hi", ~v, bdiv[0][15:8]);
    chk("baud_b", 8'h00, bdiv[1][7:0]);
    rdc("int_stat", 1'b0, 3'h2, ist[0]);
    wr(1'b0, 3'h2, 8'h07);
    wr(1'b0, 3'h3, 8'hbf);
    wr(1'b0, 3'h2, 8'h10);
    wr(1'b0, 3'h1, 8'h40);
    for (int a = 4; a < 8; a++) wr(1'b0, a[2:0], 8'(a * 37));
    for (int a = 4; a < 8; a++) rdc("flow_chr", 1'b0, a[2:0], 8'(a * 37));
    rdc("feat_ctl", 1'b0, 3'h1, 8'h40);
    rdc("enh_fn", 1'b0, 3'h2, 8'h10);
    rdc("lvl_enh", 1'b0, 3'h0, flv[0]);
    wr(1'b0, 3'h0, 8'h55);
    wr(1'b0, 3'h3, 8'h80);
    wr(1'b0, 3'h2, 8'hfa);
    rdc("div_frac", 1'b0, 3'h2, 8'h0a);
    wr(1'b0, 3'h3, 8'h03);
    rdc("fifo_lvl", 1'b0, 3'h7, flv[0]);
    wr(1'b0, 3'h7, 8'h99);
    chk("pulses", 8'h54, seen[7:0]);
    chk("load_dat", 8'h99, ldat);
    wr(1'b0, 3'h3, 8'hbf);
    wr(1'b0, 3'h1, 8'h00);
    wr(1'b0, 3'h3, 8'h03);
    v = 8'($random(seed));
    wr(1'b0, 3'h7, v);
    wr(1'b1, 3'h7, ~v);
    rdc("scratch", 1'b0, 3'h7, v);
    rdc("rx_hold", 1'b0, 3'h0, rxh[0]);
    wr(1'b0, 3'h0, v);
    chk("pop_load", 8'h05, {4'h0, seen[9:8], seen[1:0]});
    chk("tx_data", v, ldat);
    wr(1'b0, 3'h1, ~v);
    wr(1'b0, 3'h5, v);
    wr(1'b0, 3'h6, v);
    rdc("line_st", 1'b0, 3'h5, lst[0]);
    rdc("int_en", 1'b0, 3'h1, ~v);
    wr(1'b0, 3'h4, 8'h03);
    chk("mdm_pins", 8'h00, {6'h0, rts_n[0], dtr_n[0]});
    rdc("mdm_ctl", 1'b0, 3'h4, 8'h03);
    wr(1'b0, 3'h4, 8'h13);
    chk("loop_pin", 8'h0f, {4'h0, lb[0], tx[0], rts_n[0], dtr_n[0]});
    mdm_n <= 2'b00;
    repeat (8) begin
      @(posedge clk_i);
      #1;
      q[0] = txs[0];
      @(posedge clk_i);
      #1;
      chk("loop_rx", {7'h0, q[0]}, {7'h0, crx[0]});
    end
    host_model_i.access(1'b0, 3'h6, 1'b0, 8'h00, q);
    chk("mstat", 8'h03, {4'h0, q[7:4]});
    wr(1'b0, 3'h4, 8'h03);
    chk("loop_off", 8'h01, {5'h0, lb, crx[0]});
    tally_and_finish();
  end
endmodule
